// ===== rtl/slgs_pkg.sv
package slgs_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_NS       = 1000000;
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STD_PI   = 8'h04;
    localparam logic [7:0] OFS_STD_D    = 8'h08;
    localparam logic [7:0] OFS_START_PI = 8'h0c;
    localparam logic [7:0] OFS_START_D  = 8'h10;
    localparam logic [7:0] OFS_SS_PI    = 8'h14;
    localparam logic [7:0] OFS_SS_D     = 8'h18;
    localparam logic [7:0] OFS_REL_PI   = 8'h1c;
    localparam logic [7:0] OFS_REL_D    = 8'h20;
    localparam logic [7:0] OFS_STOP_I   = 8'h24;
    localparam logic [7:0] OFS_TIME_A   = 8'h28;
    localparam logic [7:0] OFS_TIME_B   = 8'h2c;
    localparam logic [7:0] OFS_STATUS   = 8'h30;
    localparam logic [7:0] OFS_GAIN_PI  = 8'h34;
    localparam logic [7:0] OFS_GAIN_D   = 8'h38;

    // CTRL fields
    localparam int CTRL_EN_START = 0;
    localparam int CTRL_EN_REL   = 1;
    localparam int CTRL_EN_SS    = 2;
    localparam int CTRL_EN_STOP  = 3;
    localparam int CTRL_ARM_TEST = 4;
    localparam int CTRL_PCT_LSB  = 16;

    // gain set indices
    localparam int GS_STD   = 0;
    localparam int GS_START = 1;
    localparam int GS_SS    = 2;
    localparam int GS_REL   = 3;
    localparam int GS_STOP  = 4;

    // gains are unsigned 8.8 fixed point
    localparam logic [15:0] GAIN_4_0 = 16'h0400;
    localparam logic [15:0] GAIN_2_0 = 16'h0200;
    localparam logic [15:0] GAIN_0_0 = 16'h0000;

    // times in milliseconds
    localparam logic [15:0] RST_START_MS    = 16'h012c;
    localparam logic [15:0] RST_SS_DELAY_MS = 16'h03e8;
    localparam logic [15:0] RST_SS_TIME_MS  = 16'h03e8;
    localparam logic [15:0] RST_REL_TIME_MS = 16'h03e8;
    localparam logic [8:0]  RST_TEST_PCT    = 9'h00a;

    localparam logic [8:0]  PCT_MAX         = 9'h12c;
    localparam logic [8:0]  PCT_FAULT_ARM   = 9'h014;
    localparam logic [15:0] MV_CMD_PER_PCT  = 16'h001e;
    localparam logic [15:0] MV_FB_PER_PCT   = 16'h0018;

    typedef struct packed {
        logic [15:0] p;
        logic [15:0] i;
        logic [15:0] d;
    } slgs_gain_t;

    typedef enum logic [3:0] {
        PH_IDLE, PH_START, PH_RUN, PH_SS_WAIT, PH_SS, PH_DECEL, PH_RELEV, PH_REL_OUT
    } slgs_phase_t;

    // linear blend a -> b at e of d; lands on b once e reaches d
    function automatic logic [15:0] slgs_interp(input logic [15:0] a,
                                                input logic [15:0] b,
                                                input logic [15:0] e,
                                                input logic [15:0] d);
        logic signed [17:0] diff;
        logic signed [34:0] prod;
        logic signed [34:0] q;
        logic signed [17:0] r;
        diff = $signed({2'b00, b}) - $signed({2'b00, a});
        prod = diff * $signed({1'b0, e});
        q    = (d == 16'h0000) ? 35'sd0 : prod / $signed({19'h0, d});
        r    = $signed({2'b00, a}) + q[17:0];
        if (d == 16'h0000 || e >= d) begin
            return b;
        end
        return r[15:0];
    endfunction : slgs_interp

endpackage : slgs_pkg

// ===== rtl/slgs_top.sv
//Function
//- standard gain set is the baseline that blends leave from or return to; decel returns to it with the stop integral when enabled
//- optional gain sets act only when enabled, else standard applies
//- normal run start applies start set, blends to standard over start time
//- after steady speed and delay, blend standard to steady-state over its time
//- on deceleration, blend steady-state back to standard in half that time
//- transition delay is timed from reaching steady speed, then blend starts
//- relevel set applies when enabled, returns to standard once level stable
//- relevel transition time resets to one second
//- stop integral gain applies during normal deceleration when enabled
//- armature test commands configured percent of rating, up to 300 percent
//- armature test removes field and brake voltage
//- field removal follows acceptance of the configuration selecting the test
//- test current commanded only while inspection up or down is held
//- up gives positive composite, down negative; drive test point opposite
//- full rated request scales to 3.0 V command and 2.4 V feedback
//- requests of 20 percent or more arm current fault checks
//- composite command leaves as two paths, each half the total
`timescale 1ns/1ns
`default_nettype none
module slgs_top
    import slgs_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        RUN,
    input  wire logic        RELEVEL,
    input  wire logic        AT_SPEED,
    input  wire logic        DECEL,
    input  wire logic        LEVEL_STABLE,
    input  wire logic        INSP_UP,
    input  wire logic        INSP_DN,
    input  wire logic        FIELD_REQ,
    input  wire logic        BRAKE_REQ,
    output slgs_gain_t       GAIN,
    output logic             FIELD_EN,
    output logic             BRAKE_EN,
    output logic             TEST_ACTIVE,
    output logic signed [15:0] CMD_COMP_MV,
    output logic signed [15:0] CMD_PATH_A_MV,
    output logic signed [15:0] CMD_PATH_B_MV,
    output logic signed [15:0] DRIVE_TP_MV,
    output logic signed [15:0] FB_EXPECT_MV,
    output logic             FAULT_ARM
);

    slgs_gain_t  gset [0:4];
    logic [31:0] ctrl;
    logic [15:0] t_start;
    logic [15:0] t_rel;
    logic [15:0] t_ss_delay;
    logic [15:0] t_ss;

    slgs_phase_t phase;
    slgs_phase_t next_phase;
    slgs_gain_t  from_g;
    slgs_gain_t  to_g;
    slgs_gain_t  next_from;
    slgs_gain_t  next_to;
    logic [15:0] dur;
    logic [15:0] next_dur;
    logic [15:0] elapsed;
    logic        launch;
    logic        done;
    logic [31:0] tick_cnt;
    logic        tick;
    logic        run_q;
    logic        relv_q;
    logic        spd_q;
    logic        dec_q;
    logic        lvl_q;

    wire logic wr_acc = PSEL && PENABLE && PWRITE;
    wire logic setup  = PSEL && !PENABLE;
    wire logic [5:0] widx = PADDR[7:2];

    // register file
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ctrl       <= {7'h00, RST_TEST_PCT, 16'h0000};
            t_start    <= RST_START_MS;
            t_rel      <= RST_REL_TIME_MS;
            t_ss_delay <= RST_SS_DELAY_MS;
            t_ss       <= RST_SS_TIME_MS;
            gset[GS_STD]   <= '{GAIN_4_0, GAIN_4_0, GAIN_0_0};
            gset[GS_START] <= '{GAIN_4_0, GAIN_4_0, GAIN_0_0};
            gset[GS_SS]    <= '{GAIN_2_0, GAIN_2_0, GAIN_0_0};
            gset[GS_REL]   <= '{GAIN_4_0, GAIN_4_0, GAIN_0_0};
            gset[GS_STOP]  <= '{GAIN_0_0, GAIN_4_0, GAIN_0_0};
        end else if (wr_acc) begin
            case (PADDR)
                // a ctrl write is the configuration being accepted
                OFS_CTRL:     ctrl <= PWDATA & 32'h01ff_001f;
                OFS_STD_PI:   begin
                    gset[GS_STD].p <= PWDATA[15:0];
                    gset[GS_STD].i <= PWDATA[31:16];
                end
                OFS_START_PI: begin
                    gset[GS_START].p <= PWDATA[15:0];
                    gset[GS_START].i <= PWDATA[31:16];
                end
                OFS_SS_PI:    begin
                    gset[GS_SS].p <= PWDATA[15:0];
                    gset[GS_SS].i <= PWDATA[31:16];
                end
                OFS_REL_PI:   begin
                    gset[GS_REL].p <= PWDATA[15:0];
                    gset[GS_REL].i <= PWDATA[31:16];
                end
                OFS_STD_D:    gset[GS_STD].d   <= PWDATA[15:0];
                OFS_START_D:  gset[GS_START].d <= PWDATA[15:0];
                OFS_SS_D:     gset[GS_SS].d    <= PWDATA[15:0];
                OFS_REL_D:    gset[GS_REL].d   <= PWDATA[15:0];
                OFS_STOP_I:   gset[GS_STOP].i  <= PWDATA[31:16];
                OFS_TIME_A:   begin
                    t_start <= PWDATA[15:0];
                    t_rel   <= PWDATA[31:16];
                end
                OFS_TIME_B:   begin
                    t_ss_delay <= PWDATA[15:0];
                    t_ss       <= PWDATA[31:16];
                end
                default: ;
            endcase
        end
    end

    // read data is latched in the setup phase, so every access is zero-wait
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= 1'b1;
            if (setup) begin
                PSLVERR <= (PADDR[1:0] != 2'b00) || (widx > 6'h0e);
                case (PADDR)
                    OFS_CTRL:     PRDATA <= ctrl;
                    OFS_STD_PI:   PRDATA <= {gset[GS_STD].i, gset[GS_STD].p};
                    OFS_STD_D:    PRDATA <= {16'h0000, gset[GS_STD].d};
                    OFS_START_PI: PRDATA <= {gset[GS_START].i, gset[GS_START].p};
                    OFS_START_D:  PRDATA <= {16'h0000, gset[GS_START].d};
                    OFS_SS_PI:    PRDATA <= {gset[GS_SS].i, gset[GS_SS].p};
                    OFS_SS_D:     PRDATA <= {16'h0000, gset[GS_SS].d};
                    OFS_REL_PI:   PRDATA <= {gset[GS_REL].i, gset[GS_REL].p};
                    OFS_REL_D:    PRDATA <= {16'h0000, gset[GS_REL].d};
                    OFS_STOP_I:   PRDATA <= {gset[GS_STOP].i, 16'h0000};
                    OFS_TIME_A:   PRDATA <= {t_rel, t_start};
                    OFS_TIME_B:   PRDATA <= {t_ss, t_ss_delay};
                    OFS_STATUS:   PRDATA <= {26'h0, done, TEST_ACTIVE, phase};
                    OFS_GAIN_PI:  PRDATA <= {GAIN.i, GAIN.p};
                    OFS_GAIN_D:   PRDATA <= {16'h0000, GAIN.d};
                    default:      PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control tick, restarted at each launch so a blend's first step is a full tick
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b0;
        end else begin
            tick     <= !launch && (tick_cnt == TICK_LEN - 1);
            tick_cnt <= (launch || tick_cnt == TICK_LEN - 1) ? 32'h0000_0000 : tick_cnt + 32'h1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            run_q  <= 1'b0;
            relv_q <= 1'b0;
            spd_q  <= 1'b0;
            dec_q  <= 1'b0;
            lvl_q  <= 1'b0;
        end else begin
            run_q  <= RUN;
            relv_q <= RELEVEL;
            spd_q  <= AT_SPEED;
            dec_q  <= DECEL;
            lvl_q  <= LEVEL_STABLE;
        end
    end

    // gain phase sequencer
    assign done = (elapsed >= dur);

    always_comb begin
        slgs_gain_t std_g;
        slgs_gain_t dec_g;
        std_g      = gset[GS_STD];
        dec_g      = std_g;
        if (ctrl[CTRL_EN_STOP]) begin
            dec_g.i = gset[GS_STOP].i;
        end
        next_phase = phase;
        next_from  = from_g;
        next_to    = to_g;
        next_dur   = dur;
        launch     = 1'b1;
        if ((!RUN && run_q) || (!RELEVEL && relv_q)) begin
            next_phase = PH_IDLE;
            next_from  = std_g;
            next_to    = std_g;
            next_dur   = 16'h0000;
        end else if (RUN && !run_q) begin
            next_phase = PH_START;
            next_to    = std_g;
            next_from  = ctrl[CTRL_EN_START] ? gset[GS_START] : std_g;
            next_dur   = ctrl[CTRL_EN_START] ? t_start : 16'h0000;
        end else if (RELEVEL && !relv_q) begin
            next_phase = PH_RELEV;
            next_from  = ctrl[CTRL_EN_REL] ? gset[GS_REL] : std_g;
            next_to    = next_from;
            next_dur   = 16'h0000;
        end else if (DECEL && !dec_q && (phase == PH_START || phase == PH_RUN ||
                     phase == PH_SS_WAIT || phase == PH_SS)) begin
            next_phase = PH_DECEL;
            next_from  = GAIN;
            next_to    = dec_g;
            next_dur   = ctrl[CTRL_EN_SS] ? {1'b0, t_ss[15:1]} : 16'h0000;
        end else if (AT_SPEED && !spd_q && ctrl[CTRL_EN_SS] &&
                     (phase == PH_START || phase == PH_RUN)) begin
            // delay runs on the same elapsed counter with the gains held
            next_phase = PH_SS_WAIT;
            next_from  = GAIN;
            next_to    = GAIN;
            next_dur   = t_ss_delay;
        end else if (phase == PH_SS_WAIT && done) begin
            next_phase = PH_SS;
            next_from  = GAIN;
            next_to    = gset[GS_SS];
            next_dur   = t_ss;
        end else if (phase == PH_RELEV && LEVEL_STABLE && !lvl_q) begin
            next_phase = PH_REL_OUT;
            next_from  = GAIN;
            next_to    = std_g;
            next_dur   = t_rel;
        end else if (phase == PH_START && done) begin
            next_phase = PH_RUN;
            launch     = 1'b0;
        end else begin
            launch     = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            phase   <= PH_IDLE;
            from_g  <= '{GAIN_4_0, GAIN_4_0, GAIN_0_0};
            to_g    <= '{GAIN_4_0, GAIN_4_0, GAIN_0_0};
            dur     <= 16'h0000;
            elapsed <= 16'h0000;
        end else begin
            phase <= next_phase;
            if (launch) begin
                from_g  <= next_from;
                to_g    <= next_to;
                dur     <= next_dur;
                elapsed <= 16'h0000;
            end else if (tick && !done) begin
                elapsed <= elapsed + 16'h0001;
            end
        end
    end

    // gains step at a launch that loads a new set, and when elapsed does, once per control tick
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            GAIN <= '{GAIN_4_0, GAIN_4_0, GAIN_0_0};
        end else begin
            GAIN.p <= slgs_interp(from_g.p, to_g.p, elapsed, dur);
            GAIN.i <= slgs_interp(from_g.i, to_g.i, elapsed, dur);
            GAIN.d <= slgs_interp(from_g.d, to_g.d, elapsed, dur);
        end
    end

    // armature current test
    logic [8:0]         pct;
    logic               cmd_on;
    logic signed [15:0] mag_cmd;
    logic signed [15:0] mag_fb;
    logic signed [15:0] comp;
    logic signed [15:0] fb;

    always_comb begin
        pct     = (ctrl[CTRL_PCT_LSB +: 9] > PCT_MAX) ? PCT_MAX : ctrl[CTRL_PCT_LSB +: 9];
        // both directions held at once commands nothing
        cmd_on  = ctrl[CTRL_ARM_TEST] && (INSP_UP != INSP_DN);
        mag_cmd = $signed(16'({7'h00, pct} * MV_CMD_PER_PCT));
        mag_fb  = $signed(16'({7'h00, pct} * MV_FB_PER_PCT));
        comp    = !cmd_on ? 16'sh0000 : (INSP_UP ? mag_cmd : -mag_cmd);
        fb      = !cmd_on ? 16'sh0000 : (INSP_UP ? mag_fb : -mag_fb);
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            FIELD_EN      <= 1'b0;
            BRAKE_EN      <= 1'b0;
            TEST_ACTIVE   <= 1'b0;
            CMD_COMP_MV   <= 16'sh0000;
            CMD_PATH_A_MV <= 16'sh0000;
            CMD_PATH_B_MV <= 16'sh0000;
            DRIVE_TP_MV   <= 16'sh0000;
            FB_EXPECT_MV  <= 16'sh0000;
            FAULT_ARM     <= 1'b0;
        end else begin
            TEST_ACTIVE   <= ctrl[CTRL_ARM_TEST];
            FIELD_EN      <= FIELD_REQ && !ctrl[CTRL_ARM_TEST];
            BRAKE_EN      <= BRAKE_REQ && !ctrl[CTRL_ARM_TEST];
            CMD_COMP_MV   <= comp;
            CMD_PATH_A_MV <= comp - (comp >>> 1);
            CMD_PATH_B_MV <= comp >>> 1;
            DRIVE_TP_MV   <= -comp;
            FB_EXPECT_MV  <= fb;
            FAULT_ARM     <= cmd_on && (pct >= PCT_FAULT_ARM);
        end
    end

endmodule : slgs_top
`default_nettype wire

// ===== dv/slgs_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
module slgs_drive_model (
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    input  wire logic signed [15:0] path_a_mv,
    input  wire logic signed [15:0] path_b_mv,
    input  wire logic               field_en,
    input  wire logic               brake_en,
    output logic signed [15:0]      arm_mv,
    output logic                    rotates
);
    // the bridge adds both paths, so a dead path shows up as half the current
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            arm_mv <= 16'sh0000;
        end else begin
            arm_mv <= path_a_mv + path_b_mv;
        end
    end
    // current with field and brake energised would turn the motor
    assign rotates = field_en && brake_en && (arm_mv != 16'sh0000);
endmodule : slgs_drive_model
`default_nettype wire

// ===== dv/slgs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module slgs_checker
    import slgs_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input wire logic               CLK_SYS,
    input wire logic               NRST,
    input wire logic               PSEL,
    input wire logic               PENABLE,
    input wire logic               PWRITE,
    input wire logic [7:0]         PADDR,
    input wire logic               RUN,
    input wire logic               RELEVEL,
    input wire logic               AT_SPEED,
    input wire logic               DECEL,
    input wire logic               LEVEL_STABLE,
    input wire logic               INSP_UP,
    input wire logic               INSP_DN,
    input wire slgs_gain_t         GAIN,
    input wire logic               FIELD_EN,
    input wire logic               BRAKE_EN,
    input wire logic               TEST_ACTIVE,
    input wire logic signed [15:0] CMD_COMP_MV,
    input wire logic signed [15:0] CMD_PATH_A_MV,
    input wire logic signed [15:0] CMD_PATH_B_MV,
    input wire logic signed [15:0] DRIVE_TP_MV,
    input wire logic signed [15:0] FB_EXPECT_MV,
    input wire logic               FAULT_ARM
);
    logic [4:0] ctl_in;
    assign ctl_in = {RUN, RELEVEL, AT_SPEED, DECEL, LEVEL_STABLE};
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);
    field_off_a: assert property (TEST_ACTIVE |-> !FIELD_EN && !BRAKE_EN)
        else $error("field or brake energised in armature test");
    test_accept_a: assert property ($rose(TEST_ACTIVE) |->
        $past(PSEL && PENABLE && PWRITE && PADDR == OFS_CTRL, 2))
        else $error("test without write");
    insp_hold_a: assert property (!$past(INSP_UP) && !$past(INSP_DN) |->
        CMD_COMP_MV == 16'sh0000) else $error("current without inspection command");
    sign_up_a: assert property ($past(INSP_UP && !INSP_DN) |-> CMD_COMP_MV >= 0)
        else $error("up command gave negative current");
    sign_dn_a: assert property ($past(INSP_DN && !INSP_UP) |-> CMD_COMP_MV <= 0)
        else $error("down command gave positive current");
    tp_oppose_a: assert property (DRIVE_TP_MV == -CMD_COMP_MV)
        else $error("drive test point not opposite");
    half_paths_a: assert property (CMD_PATH_B_MV == (CMD_COMP_MV >>> 1) &&
        CMD_PATH_A_MV + CMD_PATH_B_MV == CMD_COMP_MV) else $error("paths do not split");
    cmd_limit_a: assert property (CMD_COMP_MV <= 16'sh2328 && CMD_COMP_MV >= -16'sh2328)
        else $error("command beyond three times rated");
    fb_scale_a: assert property (FB_EXPECT_MV * 5 == CMD_COMP_MV * 4)
        else $error("feedback scale wrong");
    fault_arm_a: assert property (FAULT_ARM ==
        (CMD_COMP_MV >= 16'sh0258 || CMD_COMP_MV <= -16'sh0258)) else $error("fault arm wrong");
    // a blend moves once per tick, so no two gain steps sit closer than a tick
    gain_step_a: assert property ((TICK_LEN > 2) && $changed(GAIN) && $stable(ctl_in) &&
        $past(ctl_in) == $past(ctl_in, 2) |=> $stable(GAIN) [*2]) else $error("gain stepped early");
    cover property ($rose(TEST_ACTIVE));
    cover property (FAULT_ARM && CMD_COMP_MV < 0);
    cover property ($rose(DECEL) ##7 $changed(GAIN));
endmodule : slgs_checker
bind slgs_top slgs_checker #(.TICK_LEN(TICK_LEN)) chk_u (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .RUN(RUN), .RELEVEL(RELEVEL), .AT_SPEED(AT_SPEED), .DECEL(DECEL),
    .LEVEL_STABLE(LEVEL_STABLE), .INSP_UP(INSP_UP), .INSP_DN(INSP_DN), .GAIN(GAIN),
    .FIELD_EN(FIELD_EN), .BRAKE_EN(BRAKE_EN), .TEST_ACTIVE(TEST_ACTIVE),
    .CMD_COMP_MV(CMD_COMP_MV), .CMD_PATH_A_MV(CMD_PATH_A_MV), .CMD_PATH_B_MV(CMD_PATH_B_MV),
    .DRIVE_TP_MV(DRIVE_TP_MV), .FB_EXPECT_MV(FB_EXPECT_MV), .FAULT_ARM(FAULT_ARM)
);
`default_nettype wire

// ===== dv/slgs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module slgs_tb_top
    import slgs_pkg::*;
;
    typedef struct {
        string       name;
        logic [63:0] exp;
    } slgs_note_t;
    logic clk_sys, nrst, psel, penable, pwrite, run, relevel, at_speed, decel, level_stable;
    logic insp_up, insp_dn, field_req, brake_req, pready, pslverr;
    logic field_en, brake_en, test_active, fault_arm, rotates;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, lfsr;
    slgs_gain_t         gain;
    logic signed [15:0] cmd_comp, path_a, path_b, drive_tp, fb_exp, arm_mv;
    slgs_note_t         notes[$];
    slgs_note_t         cur;
    int                 n_mismatch, num_checks;
    int                 pct_tab[5] = '{15, 20, 100, 300, 400};
    logic [31:0] rst_tab[15] = '{32'h000a0000, 32'h04000400, 32'h0, 32'h04000400, 32'h0,
        32'h02000200, 32'h0, 32'h04000400, 32'h0, 32'h04000000, 32'h03e8012c, 32'h03e803e8,
        32'h20, 32'h04000400, 32'h0};
    slgs_top #(.TICK_LEN(4)) dut_u (
        .CLK_SYS(clk_sys), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RUN(run), .RELEVEL(relevel), .AT_SPEED(at_speed), .DECEL(decel),
        .LEVEL_STABLE(level_stable), .INSP_UP(insp_up), .INSP_DN(insp_dn),
        .FIELD_REQ(field_req), .BRAKE_REQ(brake_req), .GAIN(gain), .FIELD_EN(field_en),
        .BRAKE_EN(brake_en), .TEST_ACTIVE(test_active), .CMD_COMP_MV(cmd_comp),
        .CMD_PATH_A_MV(path_a), .CMD_PATH_B_MV(path_b), .DRIVE_TP_MV(drive_tp),
        .FB_EXPECT_MV(fb_exp), .FAULT_ARM(fault_arm)
    );
    slgs_drive_model drv_u (
        .clk_sys(clk_sys), .nrst(nrst), .path_a_mv(path_a), .path_b_mv(path_b),
        .field_en(field_en), .brake_en(brake_en), .arm_mv(arm_mv), .rotates(rotates)
    );
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [63:0] observe(input string nm);
        case (nm)
            "PRDATA":  return 64'(prdata);
            "PSLVERR": return 64'(pslverr);
            "GAIN":    return 64'(gain);
            "FLAGS":   return 64'({field_en, brake_en, test_active});
            "CMD":     return 64'(cmd_comp);
            "PATH_A":  return 64'(path_a);
            "PATH_B":  return 64'(path_b);
            "TP":      return 64'(drive_tp);
            "FB":      return 64'(fb_exp);
            "FAULT":   return 64'(fault_arm);
            "ARM":     return 64'(arm_mv);
            "ROT":     return 64'(rotates);
            default:   return {64{1'bx}};
        endcase
    endfunction : observe
    task automatic compare(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : compare
    task automatic exp_v(input string nm, input logic [63:0] v);
        slgs_note_t n;
        n.name = nm;
        n.exp = v;
        notes.push_back(n);
    endtask : exp_v
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    // one idle cycle after each transfer keeps psel from being driven twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        apb(1'b0, a, 32'h0);
        exp_v("PRDATA", 64'(e));
        exp_v("PSLVERR", 64'(err));
    endtask : rd
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    always @(negedge clk_sys) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            compare(cur.name, cur.exp, observe(cur.name));
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_mismatch++;
        end_sim();
    end
    initial begin
        int p, s, c;
        {psel, penable, pwrite, run, relevel, at_speed, decel, level_stable, nrst} = '0;
        {insp_up, insp_dn, field_req, brake_req, paddr, pwdata} = '0;
        lfsr = 32'h53f8;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        cyc(2);
        exp_v("GAIN", 48'h0400_0400_0000);
        for (int k = 0; k < 15; k++) rd(8'(4 * k), rst_tab[k], 1'b0);
        rd(8'h3c, 32'h0, 1'b1);
        rd(8'h02, 32'h0, 1'b1);
        run <= 1'b1;
        cyc(4);
        exp_v("GAIN", 48'h0400_0400_0000);
        at_speed <= 1'b1;
        cyc(96);
        exp_v("GAIN", 48'h0400_0400_0000);
        {run, at_speed} <= 2'b00;
        apb(1'b1, OFS_START_PI, 32'h06000800);
        apb(1'b1, OFS_START_D, 32'h00000100);
        apb(1'b1, OFS_STOP_I, 32'h03000000);
        apb(1'b1, OFS_REL_PI, 32'h05000500);
        apb(1'b1, OFS_REL_D, 32'h00000080);
        apb(1'b1, OFS_TIME_A, 32'h03e800fa);
        apb(1'b1, OFS_TIME_B, 32'h01f40014);
        rd(OFS_STOP_I, 32'h03000000, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h000a000d);
        run <= 1'b1;
        cyc(2);
        exp_v("GAIN", 48'h0800_0600_0100);
        cyc(4 * 250 + 12);
        exp_v("GAIN", 48'h0400_0400_0000);
        at_speed <= 1'b1;
        cyc(4 * 20 - 4);
        exp_v("GAIN", 48'h0400_0400_0000);
        cyc(4 * 500 + 24);
        exp_v("GAIN", 48'h0200_0200_0000);
        decel <= 1'b1;
        cyc(4 * 250 + 12);
        exp_v("GAIN", 48'h0400_0300_0000);
        {run, at_speed, decel} <= 3'b000;
        apb(1'b1, OFS_CTRL, 32'h000a0002);
        relevel <= 1'b1;
        cyc(2);
        exp_v("GAIN", 48'h0500_0500_0080);
        cyc(40);
        exp_v("GAIN", 48'h0500_0500_0080);
        level_stable <= 1'b1;
        cyc(4 * 1000 + 12);
        exp_v("GAIN", 48'h0400_0400_0000);
        {relevel, level_stable, field_req, brake_req} <= 4'b0011;
        cyc(2);
        exp_v("FLAGS", 64'h6);
        for (int k = 0; k < 7; k++) begin
            lfsr = lfsr_next(lfsr);
            p = (k < 5) ? pct_tab[k] : int'(lfsr[8:0]);
            apb(1'b1, OFS_CTRL, 32'h10 | (32'(p) << 16));
            exp_v("FLAGS", 64'h1);
            for (int j = 0; j < 4; j++) begin
                insp_up <= (j == 0 || j == 2);
                insp_dn <= (j == 1 || j == 2);
                cyc(2);
                s = (j == 0) ? 1 : ((j == 1) ? -1 : 0);
                c = s * ((p > 300) ? 300 : p) * 30;
                exp_v("CMD", 64'(c));
                exp_v("PATH_B", 64'(c >>> 1));
                exp_v("PATH_A", 64'(c - (c >>> 1)));
                exp_v("TP", 64'(-c));
                exp_v("FB", 64'(c / 30 * 24));
                exp_v("FAULT", 64'(s != 0 && p >= 20));
                exp_v("ARM", 64'(c));
                exp_v("ROT", 64'h0);
            end
        end
        {insp_up, insp_dn} <= 2'b00;
        apb(1'b1, OFS_CTRL, 32'h000a0000);
        exp_v("FLAGS", 64'h6);
        cyc(2);
        end_sim();
    end
endmodule : slgs_tb_top
`default_nettype wire
